/* hdl/tpg_pkg.sv */
// Package: register map, field positions and reset values of the timer-based PWM block
//
// Contract
// RQ1 - Duty resolved to ten bits
// RQ2 - Channels share period, own duty each
// RQ3 - Postscaler never affects modulator
// RQ4 - Outputs go active when count clears
// RQ5 - Output inactive when time base equals duty
// RQ6 - Duty at or above limit: never cleared
// RQ7 - Shadow duty reloaded only at period match
// RQ8 - Software writes both duty halves before match
// RQ9 - Invert bit inverts channel output
// RQ10 - Period is (limit+1)*4*clock*prescale
// RQ11 - After match: clear, activate, latch duty
// RQ12 - Zero duty keeps output inactive
// RQ13 - Duty registers writable at any time
// RQ14 - Time base is count plus two quarters
// RQ15 - Undivided prescale advances on system clock
// RQ16 - Pulse lasts duty times clock times prescale
// RQ17 - Pulse beyond period leaves pin unchanged
// RQ18 - Software clears pin direction to drive; this block has no direction bit and always drives o_pwm
// RQ19 - Full resolution only at maximum limit
// RQ20 - Per-channel enable bit gates output
// RQ21 - Sleep freezes count and outputs
// RQ22 - Read-only bit shows output level
package tpg_pkg;

	// ****************************************************************
	// Register map (byte addresses, one word each)
	// ****************************************************************
	localparam logic [7:0] TPG_OFF_PERIOD_LIMIT = 8'h00;
	localparam logic [7:0] TPG_OFF_TIMER_CONTROL = 8'h04;
	localparam logic [7:0] TPG_OFF_TIMEBASE_COUNT = 8'h08;
	localparam logic [7:0] TPG_OFF_CH_BASE = 8'h10;
	localparam logic [7:0] TPG_OFF_CH_STRIDE = 8'h10;
	localparam logic [7:0] TPG_OFF_CH_CONTROL = 8'h00;
	localparam logic [7:0] TPG_OFF_DUTY_HIGH = 8'h04;
	localparam logic [7:0] TPG_OFF_DUTY_LOW = 8'h08;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int TPG_BIT_CH_ENABLE = 7;
	localparam int TPG_BIT_CH_LEVEL = 5;
	localparam int TPG_BIT_CH_INVERT = 4;
	localparam int TPG_BIT_TMR_ON = 2;
	localparam int TPG_DUTY_LOW_LSB = 6;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [7:0] TPG_RST_PERIOD_LIMIT = 8'hFF;
	localparam logic [7:0] TPG_RST_BYTE = 8'h00;
	localparam logic [1:0] TPG_RST_PRESCALE = 2'h0;

	// Prescale selection codes, named by their divide ratios
	typedef enum logic [1:0] {
		TPG_PRE_1 = 2'b00,
		TPG_PRE_4 = 2'b01,
		TPG_PRE_16 = 2'b10,
		TPG_PRE_64 = 2'b11
	} tpg_prescale_e;

	// Per-channel software configuration carried together
	typedef struct packed {
		logic enable;
		logic invert;
		logic [7:0] duty_high;
		logic [1:0] duty_low;
	} tpg_chan_cfg_s;

endpackage

/* hdl/tpg_pwm.sv */
// Timer-based PWM generator with shared period timer and an APB register slave
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module tpg_pwm import tpg_pkg::*; #(
	parameter int NUM_CH = 2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Power state
	input wire logic i_sleep,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata,
	// Modulated outputs
	output logic [NUM_CH-1:0] o_pwm
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Divide ratio minus one for a prescale code, as a 6-bit terminal count
	function automatic logic [5:0] pre_last(input logic [1:0] code);
		case (code)
			TPG_PRE_1: pre_last = 6'h00;
			TPG_PRE_4: pre_last = 6'h03;
			TPG_PRE_16: pre_last = 6'h0F;
			default: pre_last = 6'h3F;
		endcase
	endfunction

	// Channel index of an address in the channel window
	function automatic logic [3:0] ch_index(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - TPG_OFF_CH_BASE;
		ch_index = rel[7:4];
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] period_limit_reg;
	logic [1:0] prescale_reg;
	logic tmr_on_reg;
	logic [7:0] timebase_count_reg;
	logic [1:0] quarter_reg;
	logic [5:0] pre_cnt_reg;
	tpg_chan_cfg_s cfg_reg [NUM_CH];
	logic [9:0] shadow_reg [NUM_CH];
	logic [NUM_CH-1:0] level_reg;
	logic pready_reg;
	logic [31:0] prdata_reg;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	wire logic setup_w = i_psel && !i_penable;
	wire logic wr_w = i_psel && i_penable && i_pwrite && pready_reg;
	wire logic in_ch_w = (i_paddr >= TPG_OFF_CH_BASE)
		&& ({4'h0, ch_index(i_paddr)} < 8'(NUM_CH)) && (i_paddr[1:0] == 2'b00);
	wire logic [3:0] ch_w = ch_index(i_paddr);
	wire logic [3:0] sub_w = i_paddr[3:0];
	wire logic glob_w = (i_paddr == TPG_OFF_PERIOD_LIMIT)
		|| (i_paddr == TPG_OFF_TIMER_CONTROL) || (i_paddr == TPG_OFF_TIMEBASE_COUNT);
	wire logic ch_ok_w = in_ch_w && ((sub_w == TPG_OFF_CH_CONTROL[3:0])
		|| (sub_w == TPG_OFF_DUTY_HIGH[3:0]) || (sub_w == TPG_OFF_DUTY_LOW[3:0]));
	wire logic mapped_w = glob_w || ch_ok_w;

	// ****************************************************************
	// Time base
	// ****************************************************************
	// Sleep freezes every counter and the o_pwm outputs; the clock and the bus still run
	wire logic run_w = tmr_on_reg && !i_sleep; // RQ21
	wire logic pre_tick_w = run_w && (pre_cnt_reg == pre_last(prescale_reg)); // RQ15
	wire logic q_wrap_w = pre_tick_w && (quarter_reg == 2'h3);
	wire logic match_w = timebase_count_reg == period_limit_reg;
	// Restart one increment after the count matched the period limit
	wire logic restart_w = q_wrap_w && match_w; // RQ11
	// Full ten-bit steps only when the limit is at its top value
	wire logic [9:0] tbase_w = {timebase_count_reg, quarter_reg}; // RQ14 RQ1 RQ19

	// Prescaler and quarter counter; the postscaler has no place here
	always_ff @(posedge i_clk or negedge i_rst_n) begin // RQ3
		if (!i_rst_n) begin
			pre_cnt_reg <= 6'h00;
			quarter_reg <= 2'h0;
		end else if (run_w) begin
			pre_cnt_reg <= pre_tick_w ? 6'h00 : pre_cnt_reg + 6'h01;
			quarter_reg <= pre_tick_w ? quarter_reg + 2'h1 : quarter_reg;
		end
	end

	// Period count; period = (limit+1) * 4 * prescale clocks
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timebase_count_reg <= TPG_RST_BYTE;
		end else if (wr_w && i_paddr == TPG_OFF_TIMEBASE_COUNT) begin
			timebase_count_reg <= i_pwdata[7:0];
		end else if (restart_w) begin
			timebase_count_reg <= TPG_RST_BYTE; // RQ10 RQ2
		end else if (q_wrap_w) begin
			timebase_count_reg <= timebase_count_reg + 8'h01;
		end
	end

	// ****************************************************************
	// Global control registers
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			period_limit_reg <= TPG_RST_PERIOD_LIMIT;
			prescale_reg <= TPG_RST_PRESCALE;
			tmr_on_reg <= 1'b0;
		end else if (wr_w && i_paddr == TPG_OFF_PERIOD_LIMIT) begin
			period_limit_reg <= i_pwdata[7:0];
		end else if (wr_w && i_paddr == TPG_OFF_TIMER_CONTROL) begin
			prescale_reg <= i_pwdata[1:0];
			tmr_on_reg <= i_pwdata[TPG_BIT_TMR_ON];
		end
	end

	// ****************************************************************
	// Channels
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			wire logic sel_w = wr_w && in_ch_w && (ch_w == 4'(g));
			// Duty at or above the last time-base value {limit, 3} of the period never clears the output
			wire logic full_w = shadow_reg[g] >= {period_limit_reg, 2'b11}; // RQ6 RQ17
			// Clear on the tick that brings the time base onto the duty value,
			// so the pulse lasts exactly duty ticks and not one clock more
			wire logic clr_w = pre_tick_w && ((tbase_w + 10'h001) == shadow_reg[g])
				&& !full_w; // RQ5 RQ16
			wire logic [9:0] new_duty_w = {cfg_reg[g].duty_high, cfg_reg[g].duty_low};

			// Software copies, writable in any phase of the period
			always_ff @(posedge i_clk or negedge i_rst_n) begin // RQ13
				if (!i_rst_n) begin
					cfg_reg[g] <= '0;
				end else if (sel_w && sub_w == TPG_OFF_CH_CONTROL[3:0]) begin
					cfg_reg[g].enable <= i_pwdata[TPG_BIT_CH_ENABLE]; // RQ20
					cfg_reg[g].invert <= i_pwdata[TPG_BIT_CH_INVERT];
				end else if (sel_w && sub_w == TPG_OFF_DUTY_HIGH[3:0]) begin
					cfg_reg[g].duty_high <= i_pwdata[7:0];
				end else if (sel_w && sub_w == TPG_OFF_DUTY_LOW[3:0]) begin
					cfg_reg[g].duty_low <= i_pwdata[TPG_DUTY_LOW_LSB+1:TPG_DUTY_LOW_LSB];
				end
			end

			// Shadow duty and raw level; reload only at period restart
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					shadow_reg[g] <= 10'h000;
					level_reg[g] <= 1'b0;
				end else if (restart_w) begin
					shadow_reg[g] <= new_duty_w; // RQ7
					level_reg[g] <= (new_duty_w != 10'h000); // RQ4 RQ12
				end else if (clr_w) begin
					level_reg[g] <= 1'b0;
				end
			end

			// Registered pin: disabled channel idles low, enable gate applied last after polarity
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_pwm[g] <= 1'b0;
				end else if (!i_sleep) begin
					o_pwm[g] <= cfg_reg[g].enable && (level_reg[g] ^ cfg_reg[g].invert); // RQ9 RQ20
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Read mux
	// ****************************************************************
	logic [31:0] rd_w;
	always_comb begin
		rd_w = 32'h0000_0000;
		if (i_paddr == TPG_OFF_PERIOD_LIMIT) begin
			rd_w[7:0] = period_limit_reg;
		end else if (i_paddr == TPG_OFF_TIMER_CONTROL) begin
			rd_w[TPG_BIT_TMR_ON] = tmr_on_reg;
			rd_w[1:0] = prescale_reg;
		end else if (i_paddr == TPG_OFF_TIMEBASE_COUNT) begin
			rd_w[7:0] = timebase_count_reg;
		end else if (ch_ok_w) begin
			for (int k = 0; k < NUM_CH; k++) begin
				if (ch_w == 4'(k)) begin
					if (sub_w == TPG_OFF_CH_CONTROL[3:0]) begin
						rd_w[TPG_BIT_CH_ENABLE] = cfg_reg[k].enable;
						rd_w[TPG_BIT_CH_LEVEL] = o_pwm[k]; // RQ22
						rd_w[TPG_BIT_CH_INVERT] = cfg_reg[k].invert;
					end else if (sub_w == TPG_OFF_DUTY_HIGH[3:0]) begin
						rd_w[7:0] = cfg_reg[k].duty_high;
					end else begin
						rd_w[7:6] = cfg_reg[k].duty_low;
					end
				end
			end
		end
	end

	// ****************************************************************
	// APB handshake: no wait state, answer in the first access cycle
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			pready_reg <= setup_w;
			prdata_reg <= setup_w ? rd_w : 32'h0000_0000;
			o_pslverr <= setup_w && !mapped_w;
		end
	end

	assign o_pready = pready_reg;
	assign o_prdata = prdata_reg;

endmodule

`default_nettype wire

/* tb/tpg_pin_load.sv */
// Pin load model: times the pulses of one modulated pin
`timescale 1ns/100ps
`default_nettype none
module tpg_pin_load (
	// Clock and observed pin
	input wire logic i_clk,
	input wire logic i_pin,
	// Last complete pulse and period, in clocks
	output logic [15:0] o_high = 16'h0,
	output logic [15:0] o_period = 16'h0
);
	// ********
	// Edge timer
	// ********
	logic pin_reg = 1'b0;
	logic [15:0] cnt_reg = 16'h0;
	always_ff @(posedge i_clk) begin
		pin_reg <= i_pin;
		cnt_reg <= (i_pin && !pin_reg) ? 16'h1 : cnt_reg + 16'h1;
		if (i_pin && !pin_reg)
			o_period <= cnt_reg;
		if (!i_pin && pin_reg)
			o_high <= cnt_reg;
	end
endmodule
`default_nettype wire

/* tb/tpg_pwm_sva.sv */
// Checker: bus answer timing and output freeze of the PWM block
`timescale 1ns/100ps
`default_nettype none
module tpg_pwm_chk import tpg_pkg::*; #(
	parameter int NUM_CH = 2
) (
	// Clock, reset, power
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sleep,
	// Bus and outputs
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic [31:0] o_prdata,
	input wire logic [NUM_CH-1:0] o_pwm
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence answer_s;
		o_pready ##1 !o_pready;
	endsequence
	chk_ready_wait: assert property (setup_s |=> answer_s)
		else $error("ready not in first access cycle");
	chk_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held too long");
	chk_ready_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside access phase");
	chk_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
		else $error("ready without prior access");
	chk_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	chk_err_data: assert property (o_pslverr |-> o_prdata == 32'h0)
		else $error("refused read not zero");
	chk_data_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer");
	// Bus writes are kept out of sleep by the bench, so outputs must not move
	chk_sleep_hold: assert property (i_sleep |=> $stable(o_pwm))
		else $error("output moved in sleep");
endmodule
bind tpg_pwm tpg_pwm_chk #(.NUM_CH(NUM_CH)) tpg_pwm_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_sleep(i_sleep), .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
	.o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_pwm(o_pwm));
`default_nettype wire

/* tb/tpg_pwm_tb.sv */
// Testbench: drives the PWM block over APB and times its outputs
`timescale 1ns/100ps
`default_nettype none
module tpg_pwm_tb import tpg_pkg::*; ();
	// ********
	// Bench
	// ********
	logic clk = 1'b0, rst_n = 1'b0, sleep = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h6A05;
	logic pready, perr, er;
	logic [1:0] pwm;
	logic [15:0] hi0, hi1, per0, per1;
	int n_fail = 0;
	int checks = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	tpg_pwm #(.NUM_CH(2)) tpg_pwm_i (.i_clk(clk), .i_rst_n(rst_n), .i_sleep(sleep),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_pslverr(perr), .o_prdata(prdata), .o_pwm(pwm));
	tpg_pin_load load0_i (.i_clk(clk), .i_pin(pwm[0]), .o_high(hi0), .o_period(per0));
	tpg_pin_load load1_i (.i_clk(clk), .i_pin(pwm[1]), .o_high(hi1), .o_period(per1));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// One APB transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (t >= 20) begin
			n_fail++;
			final_report();
		end
		rd = prdata;
		er = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Both duty halves go in before the control byte
	task automatic setch(input logic [7:0] b, input logic [9:0] d, input logic [7:0] c);
		apb(1'b1, b + TPG_OFF_DUTY_HIGH, {24'h0, d[9:2]});
		apb(1'b1, b + TPG_OFF_DUTY_LOW, {24'h0, d[1:0], 6'h0});
		apb(1'b1, b + TPG_OFF_CH_CONTROL, {24'h0, c});
	endtask
	initial begin
		int l;
		int per;
		int r;
		logic [9:0] d0, d1;
		logic [31:0] c0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, TPG_OFF_PERIOD_LIMIT, 32'h0);
		chk("limit reset", {24'h0, TPG_RST_PERIOD_LIMIT}, rd);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		apb(1'b1, TPG_OFF_CH_BASE + TPG_OFF_DUTY_LOW, 32'hFF);
		apb(1'b0, TPG_OFF_CH_BASE + TPG_OFF_DUTY_LOW, 32'h0);
		chk("low bits", 32'hC0, rd);
		$display("test registers done");
		// Each prescale ratio; first two runs take the smallest and largest clearing duty
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			l = (k == 0) ? 255 : 3 + seed[3:0];
			r = 1 << (2 * k);
			seed = lfsr(seed);
			d0 = (k == 0) ? 10'h1 : (k == 1) ? 10'(4 * l + 2) : 10'(1 + seed % (4 * l + 2));
			seed = lfsr(seed);
			d1 = 10'(1 + seed % (4 * l + 2));
			apb(1'b1, TPG_OFF_TIMER_CONTROL, 32'h0);
			apb(1'b1, TPG_OFF_TIMEBASE_COUNT, 32'h0);
			apb(1'b1, TPG_OFF_PERIOD_LIMIT, 32'(l));
			setch(TPG_OFF_CH_BASE, d0, 8'h80);
			setch(TPG_OFF_CH_BASE + TPG_OFF_CH_STRIDE, d1, 8'h90);
			apb(1'b1, TPG_OFF_TIMER_CONTROL, {29'h0, 1'b1, 2'(k)});
			per = (l + 1) * 4 * r;
			cyc(3 * per + 10);
			chk("period0", 32'(per), 32'(per0));
			chk("high0", 32'(d0 * r), 32'(hi0));
			chk("period1", 32'(per), 32'(per1));
			chk("high1", 32'(per - d1 * r), 32'(hi1));
			$display("test prescale %0d done", k);
		end
		// Sleep freezes the count
		sleep <= 1'b1;
		apb(1'b0, TPG_OFF_TIMEBASE_COUNT, 32'h0);
		c0 = rd;
		cyc(100);
		apb(1'b0, TPG_OFF_TIMEBASE_COUNT, 32'h0);
		chk("sleep count", c0, rd);
		sleep <= 1'b0;
		$display("test sleep done");
		// Zero duty stays off, duty past the limit stays on
		setch(TPG_OFF_CH_BASE, 10'h0, 8'h80);
		setch(TPG_OFF_CH_BASE + TPG_OFF_CH_STRIDE, 10'h3FF, 8'h80);
		cyc(2 * per + 10);
		for (int i = 0; i < 8; i++) begin
			cyc(per / 8);
			chk("zero full", 32'h2, {30'h0, pwm});
		end
		apb(1'b0, TPG_OFF_CH_BASE + TPG_OFF_CH_STRIDE, 32'h0);
		chk("level bit", 32'hA0, rd);
		apb(1'b1, TPG_OFF_CH_BASE + TPG_OFF_CH_STRIDE, 32'h0);
		cyc(4);
		chk("disabled", 32'h0, {30'h0, pwm});
		$display("test full zero done");
		final_report();
	end
endmodule
`default_nettype wire
